//--- hdl/rlt_regs.svh
// register indices, field positions, reset values and counter limits of the event timer
`ifndef RLT_REGS_SVH
`define RLT_REGS_SVH

// register indices; the byte address on the bus is four times the index
`define RLT_IDX_MODE       16'hffb4
`define RLT_IDX_COUNT      16'hffb5
`define RLT_IDX_CKSTOP     16'hfffa
`define RLT_IDX_IRQ_STAT   16'hffc0
`define RLT_IDX_IRQ_MASK   16'hffc1

// mode register fields
`define RLT_MODE_RELOAD_BIT 7
`define RLT_MODE_DIR_MSB    6
`define RLT_MODE_DIR_LSB    5
`define RLT_MODE_SRC_MSB    2
`define RLT_MODE_SRC_LSB    0
`define RLT_MODE_FIXED_ONES 8'h18
`define RLT_MODE_STORE_MASK 8'he7

// source code that selects the external event pin
`define RLT_SRC_EXTERNAL    3'h7

// module clock stop register: a zero in this bit halts the timer
`define RLT_CKSTOP_TIMER_BIT 0

// interrupt status and mask bits
`define RLT_IRQ_WRAP_BIT    0
`define RLT_IRQ_OVER_BIT    1
`define RLT_IRQ_UNDER_BIT   2
`define RLT_IRQ_USED_MASK   8'h07

// reset values
`define RLT_MODE_RST        8'h18
`define RLT_COUNT_RST       8'h00
`define RLT_RELOAD_RST      8'h00
`define RLT_CKSTOP_RST      8'hff
`define RLT_IRQ_STAT_RST    8'h00
`define RLT_IRQ_MASK_RST    8'h00

// counter limits
`define RLT_COUNT_TOP       8'hff
`define RLT_COUNT_BOTTOM    8'h00

`endif

//--- hdl/rlt_pkg.sv
// shared types of the event timer
package rlt_pkg;

	// one register byte
	typedef logic [7:0] rlt_byte_t;

	// counting direction control held in the mode register
	typedef enum logic [1:0] {
		RLT_DIR_UP    = 2'b00,
		RLT_DIR_DOWN  = 2'b01,
		RLT_DIR_PIN   = 2'b10,
		RLT_DIR_PIN_B = 2'b11
	} rlt_dir_t;

endpackage

//--- hdl/rlt_prescaler.sv
// free-running divider giving one-cycle tick enables for the internal sources
`timescale 1ns/1ps

module rlt_prescaler #(
	parameter int PRE_W = 13
) (
	input  wire logic       clk_sys_i,
	input  wire logic       sys_rst_i,
	input  wire logic       run_i,
	output logic      [6:0] tick_o
);

	logic [PRE_W-1:0] div_reg;

	// the taps need bits up to PRE_W-1 for the slowest source
	if (PRE_W < 13) begin : g_chk
		$error("rlt_prescaler: PRE_W must be at least 13");
	end

	//////////////////////////////////////////////////////////////////////////
	// divider: held at zero while stopped so every source restarts cleanly
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || !run_i) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// tap i divides by two to the power PRE_W-2*i
	for (genvar i = 0; i < 7; i++) begin : g_tap
		localparam int W = PRE_W - 2 * i;
		always_ff @(posedge clk_sys_i) begin
			if (sys_rst_i || !run_i) begin
				tick_o[i] <= 1'b0;
			end else begin
				tick_o[i] <= &div_reg[W-1:0];
			end
		end
	end

endmodule

//--- hdl/rlt_pin_sync.sv
// three-flop synchroniser with agreement filter and rising-edge pulse per pin
`timescale 1ns/1ps

module rlt_pin_sync #(
	parameter int W = 2
) (
	input  wire logic         clk_sys_i,
	input  wire logic         sys_rst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] rise_o
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	if (W < 1) begin : g_chk
		$error("rlt_pin_sync: W must be at least 1");
	end

	//////////////////////////////////////////////////////////////////////////
	// the first flop only feeds the second, so metastability stays contained
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// a change counts once flops two and three agree
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk_sys_i) begin
			if (sys_rst_i) begin
				level_o[i] <= 1'b0;
				rise_o[i]  <= 1'b0;
			end else begin
				rise_o[i] <= (s2_reg[i] == s3_reg[i]) && s3_reg[i] && !level_o[i];
				if (s2_reg[i] == s3_reg[i]) begin
					level_o[i] <= s3_reg[i];
				end
			end
		end
	end

endmodule

//--- hdl/rlt_timer.sv
// reloadable 8-bit event timer with a classic wishbone register slave
`timescale 1ns/1ps
`include "rlt_regs.svh"

//////////////////////////////////////////////////////////////////////////////
// How it works
// - mode bit 7 low gives interval counting, high gives auto-reload
// - the mode register resets to 0x18
// - mode register is read/write: reload select, source select, direction control
// - 8-bit counter advances once per tick of the chosen internal or external source
// - mode bits 2 to 0 choose the counter's tick source
// - counter reads return the live value and never disturb counting
// - counting up past 0xff wraps to 0x00, or to reload value in reload mode
// - every overflow and underflow sets the timer interrupt request flag
// - one address: reads give the counter, writes go to the reload register
// - the counter resets to 0x00
// - writing a reload value loads it into the counter at once
// - in reload mode each overflow or underflow reloads the stored value
// - the reload register resets to 0x00
module rlt_timer #(
	parameter int PRE_W = 13
) (
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [17:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        event_pin_i,
	input  wire logic        direction_select_pin_i,
	output logic             wrap_o,
	output logic             irq_o
);

	//////////////////////////////////////////////////////////////////////////
	// declarations

	rlt_pkg::rlt_byte_t timer_mode_reg;
	rlt_pkg::rlt_byte_t count_value_reg;
	rlt_pkg::rlt_byte_t count_value_next;
	rlt_pkg::rlt_byte_t reload_value_reg;
	rlt_pkg::rlt_byte_t module_clock_stop_reg;
	rlt_pkg::rlt_byte_t irq_status_reg;
	rlt_pkg::rlt_byte_t irq_mask_reg;
	rlt_pkg::rlt_byte_t read_byte;
	rlt_pkg::rlt_dir_t  dir_mode;

	logic [15:0] reg_index;
	logic        bus_req;
	logic        bus_take;
	logic        bus_write;
	logic        wr_mode;
	logic        wr_reload;
	logic        wr_ckstop;
	logic        wr_irq_stat;
	logic        wr_irq_mask;
	logic        timer_run;
	logic        reload_mode;
	logic [2:0]  source_select_field;
	logic [6:0]  internal_tick;
	logic [1:0]  pin_level;
	logic [1:0]  pin_rise;
	logic        count_tick;
	logic        count_down;
	logic        overflow_hit;
	logic        underflow_hit;
	logic        timer_irq_flag;
	logic [7:0]  irq_set;

	//////////////////////////////////////////////////////////////////////////
	// wishbone front end

	// word index: byte address divided by four, bits 1:0 are ignored
	assign reg_index = wb_adr_i[17:2];

	// a request is taken once, on the edge that raises ack
	assign bus_req  = wb_cyc_i && wb_stb_i;
	assign bus_take = bus_req && !wb_ack_o;

	// only lane 0 carries data; a write without it is acked and dropped
	assign bus_write = bus_take && wb_we_i && wb_sel_i[0];

	// per-register write strobes
	assign wr_mode     = bus_write && (reg_index == `RLT_IDX_MODE);
	assign wr_reload   = bus_write && (reg_index == `RLT_IDX_COUNT);
	assign wr_ckstop   = bus_write && (reg_index == `RLT_IDX_CKSTOP);
	assign wr_irq_stat = bus_write && (reg_index == `RLT_IDX_IRQ_STAT);
	assign wr_irq_mask = bus_write && (reg_index == `RLT_IDX_IRQ_MASK);

	// ack one cycle after the request appears, dropped the cycle after
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_take;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// read multiplexer

	// unmapped indices read as zero; reads have no side effect at all
	always_comb begin
		read_byte = 8'h00;
		unique case (reg_index)
			`RLT_IDX_MODE: begin
				read_byte = timer_mode_reg | `RLT_MODE_FIXED_ONES;
			end
			`RLT_IDX_COUNT: begin
				read_byte = count_value_reg;
			end
			`RLT_IDX_CKSTOP: begin
				read_byte = module_clock_stop_reg;
			end
			`RLT_IDX_IRQ_STAT: begin
				read_byte = irq_status_reg;
			end
			`RLT_IDX_IRQ_MASK: begin
				read_byte = irq_mask_reg;
			end
			default: begin
				read_byte = 8'h00;
			end
		endcase
	end

	// read data is captured with ack so it stands as long as ack does
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_take && !wb_we_i) begin
			wb_dat_o <= {24'h00_0000, read_byte};
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// configuration registers

	// mode register; bits 4 and 3 are never stored, so they cannot drift
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			timer_mode_reg <= `RLT_MODE_RST & `RLT_MODE_STORE_MASK;
		end else if (wr_mode) begin
			timer_mode_reg <= wb_dat_i[7:0] & `RLT_MODE_STORE_MASK;
		end
	end

	// reload register, write-only from the bus side
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			reload_value_reg <= `RLT_RELOAD_RST;
		end else if (wr_reload) begin
			reload_value_reg <= wb_dat_i[7:0];
		end
	end

	// module clock stop; a zero in bit 0 parks the divider and the counter
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			module_clock_stop_reg <= `RLT_CKSTOP_RST;
		end else if (wr_ckstop) begin
			module_clock_stop_reg <= wb_dat_i[7:0];
		end
	end

	// interrupt mask, same layout as the status register
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			irq_mask_reg <= `RLT_IRQ_MASK_RST;
		end else if (wr_irq_mask) begin
			irq_mask_reg <= wb_dat_i[7:0] & `RLT_IRQ_USED_MASK;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// mode decode

	assign reload_mode         = timer_mode_reg[`RLT_MODE_RELOAD_BIT];
	assign source_select_field = timer_mode_reg[`RLT_MODE_SRC_MSB:`RLT_MODE_SRC_LSB];
	assign timer_run           = module_clock_stop_reg[`RLT_CKSTOP_TIMER_BIT];
	assign dir_mode = rlt_pkg::rlt_dir_t'(timer_mode_reg[`RLT_MODE_DIR_MSB:`RLT_MODE_DIR_LSB]);

	// direction: fixed by software, or handed to the direction pin
	always_comb begin
		count_down = 1'b0;
		unique case (dir_mode)
			rlt_pkg::RLT_DIR_UP: begin
				count_down = 1'b0;
			end
			rlt_pkg::RLT_DIR_DOWN: begin
				count_down = 1'b1;
			end
			rlt_pkg::RLT_DIR_PIN, rlt_pkg::RLT_DIR_PIN_B: begin
				count_down = pin_level[1]; // pin high counts down
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// tick sources

	// internal sources come from one shared divider
	rlt_prescaler #(
		.PRE_W(PRE_W)
	) u_prescaler (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.run_i     (timer_run),
		.tick_o    (internal_tick)
	);

	// bit 0 is the event pin, bit 1 the direction pin; both are asynchronous
	rlt_pin_sync #(
		.W(2)
	) u_pin_sync (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.pin_i     ({direction_select_pin_i, event_pin_i}),
		.level_o   (pin_level),
		.rise_o    (pin_rise)
	);

	// source select; the external event counts rising edges only
	always_comb begin
		count_tick = 1'b0;
		if (source_select_field == `RLT_SRC_EXTERNAL) begin
			count_tick = pin_rise[0];
		end else begin
			count_tick = internal_tick[source_select_field];
		end
		if (!timer_run) begin
			count_tick = 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// counter

	assign overflow_hit  = count_tick && !count_down && (count_value_reg == `RLT_COUNT_TOP);
	assign underflow_hit = count_tick && count_down && (count_value_reg == `RLT_COUNT_BOTTOM);

	// a reload write beats a tick in the same cycle: software intent wins
	always_comb begin
		count_value_next = count_value_reg;
		if (wr_reload) begin
			count_value_next = wb_dat_i[7:0];
		end else if (overflow_hit) begin
			if (reload_mode) begin
				count_value_next = reload_value_reg;
			end else begin
				count_value_next = `RLT_COUNT_BOTTOM;
			end
		end else if (underflow_hit) begin
			if (reload_mode) begin
				count_value_next = reload_value_reg;
			end else begin
				count_value_next = `RLT_COUNT_TOP;
			end
		end else if (count_tick) begin
			if (count_down) begin
				count_value_next = count_value_reg - 8'h01;
			end else begin
				count_value_next = count_value_reg + 8'h01;
			end
		end
	end

	// counter register
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			count_value_reg <= `RLT_COUNT_RST;
		end else begin
			count_value_reg <= count_value_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// interrupts

	// wrap on a written-over counter still counts: the tick really happened
	assign timer_irq_flag = overflow_hit || underflow_hit;

	// event vector in status layout
	always_comb begin
		irq_set                     = 8'h00;
		irq_set[`RLT_IRQ_WRAP_BIT]  = timer_irq_flag;
		irq_set[`RLT_IRQ_OVER_BIT]  = overflow_hit;
		irq_set[`RLT_IRQ_UNDER_BIT] = underflow_hit;
	end

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			irq_status_reg <= `RLT_IRQ_STAT_RST;
		end else if (wr_irq_stat) begin
			irq_status_reg <= (irq_status_reg & ~wb_dat_i[7:0]) | irq_set;
		end else begin
			irq_status_reg <= irq_status_reg | irq_set;
		end
	end

	// level interrupt, one cycle behind the status it reflects
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status_reg & irq_mask_reg);
		end
	end

	// one-cycle pulse per wrap for neighbouring logic, ignoring the mask
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			wrap_o <= 1'b0;
		end else begin
			wrap_o <= timer_irq_flag;
		end
	end

endmodule

//--- verification/rlt_timer_assertions.sv
// concurrent checks on the bus, wrap and interrupt ports of the event timer
`timescale 1ns/1ps
`include "rlt_regs.svh"

module rlt_timer_assertions (
	input wire logic        clk_sys_i,
	input wire logic        sys_rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [17:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        event_pin_i,
	input wire logic        direction_select_pin_i,
	input wire logic        wrap_o,
	input wire logic        irq_o
);
	// one clock domain, so clock and reset are given once
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	logic [15:0] idx;
	logic        rd_ack;
	logic        mapped;
	// the master holds the request while ack is up, so the live index names the answer
	assign idx    = wb_adr_i[17:2];
	assign rd_ack = wb_ack_o && !wb_we_i;
	assign mapped = idx == `RLT_IDX_MODE || idx == `RLT_IDX_COUNT || idx == `RLT_IDX_CKSTOP
		|| idx == `RLT_IDX_IRQ_STAT || idx == `RLT_IDX_IRQ_MASK;

	//////////////////////////////////////////////////////////////////////////////
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in the next cycle");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than one cycle");
	AST_ACK_QUIET: assert property (!wb_stb_i [*2] |-> !wb_ack_o)
		else $error("ack without a request");
	AST_MODE_ONES: assert property (rd_ack && idx == `RLT_IDX_MODE
		|-> wb_dat_o[4:3] == 2'b11)
		else $error("mode bits 4 and 3 not read as one");
	AST_RD_UPPER: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data above bit 7 not zero");
	AST_UNMAPPED: assert property (rd_ack && !mapped |-> wb_dat_o == 32'h00000000)
		else $error("unmapped read not zero");
	AST_WRAP_PULSE: assert property (wrap_o |=> !wrap_o)
		else $error("wrap pulse longer than one cycle");
	AST_IRQ_RISE: assert property ($rose(irq_o) |-> $past(wrap_o) || $past(wb_ack_o))
		else $error("interrupt rose without wrap or register write");
	AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wb_ack_o))
		else $error("interrupt fell without a register write");
	// main traffic: a wrap that raises the interrupt
	COV_WRAP_IRQ: cover property (wrap_o ##2 irq_o);
endmodule

//--- verification/tb_top.sv
// self-checking bench of the event timer through its wishbone registers and pins
`timescale 1ns/1ps
`include "rlt_regs.svh"

module tb_top;
	localparam logic [15:0] I_MD = `RLT_IDX_MODE;
	localparam logic [15:0] I_CT = `RLT_IDX_COUNT;
	localparam logic [15:0] I_CK = `RLT_IDX_CKSTOP;
	localparam logic [15:0] I_ST = `RLT_IDX_IRQ_STAT;
	localparam logic [15:0] I_MK = `RLT_IDX_IRQ_MASK;

	logic        clk_sys_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [17:0] wb_adr_i = 18'h00000;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        event_pin_i = 1'b0;
	logic        direction_select_pin_i = 1'b0;
	logic        wrap_o;
	logic        irq_o;
	int          bad_count = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          wraps = 0;

	// pin rows: mode, direction pin, load, pulses, count, status
	logic [7:0]  md [6] = '{8'h07, 8'h87, 8'h27, 8'ha7, 8'h47, 8'h47};
	logic        dp [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	logic [7:0]  ld [6] = '{8'hfe, 8'hfe, 8'h01, 8'h01, 8'h05, 8'h05};
	int          np [6] = '{3, 3, 3, 3, 1, 1};
	logic [7:0]  ec [6] = '{8'h01, 8'hff, 8'hfe, 8'h00, 8'h04, 8'h06};
	logic [7:0]  es [6] = '{8'h03, 8'h03, 8'h05, 8'h05, 8'h00, 8'h00};

	rlt_timer #(.PRE_W(13)) dut_u (.clk_sys_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .event_pin_i,
		.direction_select_pin_i, .wrap_o, .irq_o);

	// 40 MHz system clock
	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	//////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("counts: %0d mismatches in %0d comparisons", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask

	// classic cycle: hold until the edge that samples ack high, take data and release there
	task automatic wb_acc(input logic we, input logic [15:0] ix, input logic [7:0] d,
		input logic [3:0] sel, output logic [31:0] q);
		@(posedge clk_sys_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= {ix, 2'b00};
		wb_sel_i <= sel;
		wb_dat_i <= {24'h000000, d};
		// values read just after an edge are the ones that edge sampled
		do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] ix, input logic [7:0] d);
		logic [31:0] q;
		wb_acc(1'b1, ix, d, 4'h1, q);
	endtask

	task automatic rd_chk(input logic [15:0] ix, input logic [7:0] exp);
		logic [31:0] q;
		wb_acc(1'b0, ix, 8'h00, 4'hf, q);
		check_val(q, {24'h000000, exp});
	endtask

	// irq lags status by a cycle, so look after that edge has landed
	task automatic chk_irq(input logic exp);
		@(negedge clk_sys_i);
		check_bit(irq_o, exp);
	endtask

	// wide pulse so the pin filter passes it whole
	task automatic pulse();
		@(posedge clk_sys_i);
		event_pin_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		event_pin_i <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
	endtask

	// wrap pulses last one cycle, so they are counted at every edge that samples them
	always @(posedge clk_sys_i) begin
		if (wrap_o === 1'b1) begin
			wraps <= wraps + 1;
		end
	end

	// hang guard: the sequence needs well under a thousand cycles
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			give_verdict();
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] q1;
		logic [31:0] q2;
		int          w0;
		repeat (4) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		rd_chk(I_MD, 8'h18);
		rd_chk(I_CT, 8'h00);
		rd_chk(I_CK, 8'hff);
		rd_chk(I_ST, 8'h00);
		rd_chk(I_MK, 8'h00);
		rd_chk(16'hffc8, 8'h00);
		// untouched reload register: a reload-mode underflow from zero lands on zero again
		wr(I_MD, 8'ha7);
		pulse();
		repeat (8) @(posedge clk_sys_i);
		rd_chk(I_CT, 8'h00);
		rd_chk(I_ST, 8'h05);
		wr(I_ST, 8'h07);
		wr(I_MD, 8'h00);
		rd_chk(I_MD, 8'h18);
		wr(I_MD, 8'he7);
		rd_chk(I_MD, 8'hff);
		wb_acc(1'b1, I_MD, 8'h00, 4'he, q1);
		rd_chk(I_MD, 8'hff);
		// stopped counter keeps a written load exactly
		wr(I_CK, 8'hfe);
		wr(I_CT, 8'h5a);
		rd_chk(I_CT, 8'h5a);
		wr(I_CK, 8'hff);
		wr(I_MK, 8'h01);
		for (int i = 0; i < 6; i++) begin
			wr(I_MD, md[i]);
			direction_select_pin_i <= dp[i];
			wr(I_CT, ld[i]);
			w0 = wraps;
			repeat (np[i]) pulse();
			repeat (8) @(posedge clk_sys_i);
			rd_chk(I_CT, ec[i]);
			rd_chk(I_ST, es[i]);
			check_val(wraps - w0, {31'h0000_0000, es[i][0]});
			chk_irq(es[i][0]);
			wr(I_ST, 8'h07);
			chk_irq(1'b0);
		end
		// interrupt raised, masked, unmasked and cleared
		wr(I_MD, 8'h07);
		wr(I_CT, 8'hff);
		w0 = wraps;
		pulse();
		repeat (8) @(posedge clk_sys_i);
		check_val(wraps - w0, 32'h0000_0001);
		chk_irq(1'b1);
		wr(I_MK, 8'h00);
		chk_irq(1'b0);
		wr(I_MK, 8'h01);
		chk_irq(1'b1);
		wr(I_ST, 8'h01);
		chk_irq(1'b0);
		// fastest internal source: reads see a moving count
		wr(I_MD, 8'h06);
		wb_acc(1'b0, I_CT, 8'h00, 4'hf, q1);
		wb_acc(1'b0, I_CT, 8'h00, 4'hf, q2);
		check_bit(q1 !== q2, 1'b1);
		// a cleared run bit freezes the same fast count
		wr(I_CK, 8'hfe);
		wb_acc(1'b0, I_CT, 8'h00, 4'hf, q1);
		wb_acc(1'b0, I_CT, 8'h00, 4'hf, q2);
		check_bit(q1 === q2, 1'b1);
		give_verdict();
	end
endmodule

bind rlt_timer rlt_timer_assertions chk_u (.clk_sys_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .event_pin_i,
	.direction_select_pin_i, .wrap_o, .irq_o);
